// file: core/apm_defs.vh
`ifndef APM_DEFS_VH
`define APM_DEFS_VH

// Register offsets
`define APM_ADDR_RATE        8'h2C
`define APM_ADDR_POWER       8'h2D

// Field positions
`define APM_BIT_MEASURE      3
`define APM_BIT_LOW_POWER    4
`define APM_RATE_MSB         3
`define APM_RATE_LSB         0

// Reset values
`define APM_RATE_RST         8'h0A
`define APM_POWER_RST        8'h00
`define APM_RD_UNMAPPED      8'h00

// Rate code limits
`define APM_RATE_CODE_MAX    4'hF
`define APM_RATE_STEPS       15

// Timing
`define APM_CLK_PERIOD_NS    50
`define APM_ODR_MAX_HZ       3200
`define APM_BASE_DIV         (1000000000 / (`APM_CLK_PERIOD_NS * `APM_ODR_MAX_HZ))

`endif

// file: core/apm_rate_gen.v
`timescale 1ns/10ps
`include "apm_defs.vh"

module apm_rate_gen #(
    parameter BASE_DIV = `APM_BASE_DIV,
    parameter DIV_W    = 13,
    parameter PRE_W    = `APM_RATE_STEPS
) (
    // Clock and reset
    input  wire       i_ref_clk,
    input  wire       i_resetn,
    // Control
    input  wire       i_enable,
    input  wire [3:0] i_rate_code,
    input  wire       i_low_power,
    // Ticks
    output wire       o_odr_tick,
    output wire       o_sample_tick
);

    reg  [DIV_W-1:0] div_r;
    reg  [DIV_W-1:0] div_nxt;
    reg  [PRE_W-1:0] pre_r;
    reg  [PRE_W-1:0] pre_nxt;
    wire             base_tick;
    wire [PRE_W-1:0] mask;

    // Each code step below the top halves the rate
    function [PRE_W-1:0] rate_mask;
        input [3:0] code;
        begin
            rate_mask = ~({PRE_W{1'b1}} << (`APM_RATE_CODE_MAX - code));
        end
    endfunction

    // Cut to the counter width on purpose; DIV_W must hold BASE_DIV-1
    localparam integer     DIV_LAST_I = BASE_DIV - 1;
    localparam [DIV_W-1:0] DIV_LAST   = DIV_LAST_I[DIV_W-1:0];

    assign base_tick = i_enable && (div_r == DIV_LAST);
    assign mask      = rate_mask(i_rate_code);

    always @*
    begin
        div_nxt = div_r;
        pre_nxt = pre_r;
        if (!i_enable)
        begin
            // Counters cleared so nothing runs while idle
            div_nxt = {DIV_W{1'b0}};
            pre_nxt = {PRE_W{1'b0}};
        end
        else if (base_tick)
        begin
            div_nxt = {DIV_W{1'b0}};
            pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
        end
        else
        begin
            div_nxt = div_r + {{(DIV_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            div_r <= {DIV_W{1'b0}};
            pre_r <= {PRE_W{1'b0}};
        end
        else
        begin
            div_r <= div_nxt;
            pre_r <= pre_nxt;
        end
    end

    // Output rate from code, top code at full base rate
    assign o_odr_tick    = base_tick && ((pre_r & mask) == mask);
    // Low power samples only at output rate, trading noise for current
    assign o_sample_tick = i_low_power ? o_odr_tick : base_tick;

endmodule

// file: core/apm_power_ctrl.v
// Behaviour
// - After reset the block sits in standby with sensing off until measurement is commanded.
// - Writing one to bit 3 of the power mode register at 0x2D enters measurement mode.
// - In standby every register can be read and written.
// - Writing zero to bit 3 of the power mode register returns the block to standby.
// - Sensing is idle in standby and runs once measurement mode is entered.
// - Bit 4 of the rate register at 0x2C lowers the internal sampling rate.
// - The four-bit rate code picks the output rate, 3200 Hz at 1111 halving per step to 0000.
`timescale 1ns/10ps
`include "apm_defs.vh"

module apm_power_ctrl #(
    parameter BASE_DIV = `APM_BASE_DIV,
    parameter DIV_W    = 13
) (
    // Clock and reset
    input  wire       i_ref_clk,
    input  wire       i_resetn,
    // Register port
    input  wire       i_reg_wr,
    input  wire       i_reg_rd,
    input  wire [7:0] i_reg_addr,
    input  wire [7:0] i_reg_wdata,
    output reg  [7:0] o_reg_rdata,
    output reg        o_reg_rvalid,
    // Mode and rate
    output wire       o_measure,
    output wire       o_standby,
    output wire [3:0] o_rate_code,
    output wire       o_low_power,
    output wire       o_odr_tick,
    output wire       o_sample_tick
);

    localparam ST_STANDBY = 1'b0;
    localparam ST_MEASURE = 1'b1;

    reg  [7:0] rate_r;
    reg  [7:0] rate_nxt;
    reg  [7:0] power_r;
    reg  [7:0] power_nxt;
    reg        state_r;
    reg        state_nxt;
    reg  [7:0] rdata_nxt;

    function hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            hit = (addr == target);
        end
    endfunction

    // Writes accepted in either mode, so configuration is never locked out
    always @*
    begin
        rate_nxt  = rate_r;
        power_nxt = power_r;
        if (i_reg_wr && hit(i_reg_addr, `APM_ADDR_RATE))
            rate_nxt = i_reg_wdata;
        if (i_reg_wr && hit(i_reg_addr, `APM_ADDR_POWER))
            power_nxt = i_reg_wdata;
    end

    always @*
    begin
        rdata_nxt = `APM_RD_UNMAPPED;
        if (hit(i_reg_addr, `APM_ADDR_RATE))
            rdata_nxt = rate_r;
        else if (hit(i_reg_addr, `APM_ADDR_POWER))
            rdata_nxt = power_r;
    end

    // Mode follows the stored measure bit, one cycle after the write
    always @*
    begin
        case (state_r)
            ST_STANDBY:
                state_nxt = power_r[`APM_BIT_MEASURE] ? ST_MEASURE : ST_STANDBY;
            ST_MEASURE:
                state_nxt = power_r[`APM_BIT_MEASURE] ? ST_MEASURE : ST_STANDBY;
            default:
                state_nxt = ST_STANDBY;
        endcase
    end

    always @(posedge i_ref_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            rate_r       <= `APM_RATE_RST;
            power_r      <= `APM_POWER_RST;
            state_r      <= ST_STANDBY;
            o_reg_rdata  <= `APM_RD_UNMAPPED;
            o_reg_rvalid <= 1'b0;
        end
        else
        begin
            rate_r       <= rate_nxt;
            power_r      <= power_nxt;
            state_r      <= state_nxt;
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd)
                o_reg_rdata <= rdata_nxt;
        end
    end

    assign o_measure   = (state_r == ST_MEASURE);
    assign o_standby   = (state_r == ST_STANDBY);
    assign o_rate_code = rate_r[`APM_RATE_MSB:`APM_RATE_LSB];
    assign o_low_power = rate_r[`APM_BIT_LOW_POWER];

    // Poor codes for low power are not blocked; that choice stays with the host
    apm_rate_gen #(
        .BASE_DIV (BASE_DIV),
        .DIV_W    (DIV_W)
    ) u_rate_gen (
        .i_ref_clk     (i_ref_clk),
        .i_resetn      (i_resetn),
        .i_enable      (o_measure),
        .i_rate_code   (o_rate_code),
        .i_low_power   (o_low_power),
        .o_odr_tick    (o_odr_tick),
        .o_sample_tick (o_sample_tick)
    );

endmodule

// file: tb/apm_host.sv
`timescale 1ns/10ps
module apm_host (
    input  logic       i_ref_clk,
    input  logic [7:0] i_rdata,
    output logic       o_wr,
    output logic       o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = 18'h00000;
    // Released lines show the inverse so a stale value never passes
    task automatic xfer(input bit w, input logic [7:0] a, d, output logic [7:0] q);
        @(posedge i_ref_clk);
        #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_ref_clk);
        #1 {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
        q = i_rdata;
    endtask
endmodule

// file: tb/apm_chk_sva.sv
`timescale 1ns/10ps
module apm_chk #(parameter BASE_DIV = 4) (
    input logic       i_ref_clk, i_resetn, i_reg_wr, i_reg_rd, o_measure, o_standby,
    input logic       o_low_power, o_odr_tick, o_sample_tick, o_reg_rvalid,
    input logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input logic [3:0] o_rate_code
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    wire pw = i_reg_wr && i_reg_addr == 8'h2D;
    AST_RST: assert property ($rose(i_resetn) |-> o_standby && !o_measure)
        else $error("reset mode");
    AST_ON: assert property (pw && i_reg_wdata[3] |-> ##2 o_measure)
        else $error("no measure");
    AST_OFF: assert property (pw && !i_reg_wdata[3] |-> ##2 o_standby)
        else $error("no standby");
    AST_IDLE: assert property (o_standby |-> !o_odr_tick && !o_sample_tick)
        else $error("idle tick");
    AST_LP: assert property (o_low_power && o_measure |-> o_sample_tick == o_odr_tick)
        else $error("low power");
    AST_TOP: assert property (o_measure && &o_rate_code |-> o_odr_tick == o_sample_tick)
        else $error("top rate");
    AST_FLD: assert property (i_reg_wr && i_reg_addr == 8'h2C |=>
        {3'h0, o_low_power, o_rate_code} == ($past(i_reg_wdata) & 8'h1F)) else $error("field");
    AST_RD: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h2C |=>
        o_reg_rdata[4:0] == {o_low_power, o_rate_code}) else $error("readback");
    AST_RV: assert property (o_reg_rvalid == $past(i_reg_rd))
        else $error("read valid");
    AST_PRD: assert property (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h2D |=>
        o_reg_rdata[3] == o_measure) else $error("power readback");
    cover property (o_measure ##1 o_standby);
    cover property (pw ##2 o_measure);
    cover property (o_low_power && o_sample_tick);
    cover property (o_sample_tick && !o_odr_tick);
endmodule
bind apm_power_ctrl apm_chk #(.BASE_DIV(BASE_DIV)) chk_u (.*);

// file: tb/tb_apm_power_ctrl.sv
`timescale 1ns/10ps
module tb_apm_power_ctrl;
    logic       i_ref_clk, i_reg_wr, i_reg_rd, o_reg_rvalid, o_measure, o_standby;
    logic       o_low_power, o_odr_tick, o_sample_tick, i_resetn = 1'b0;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, q, n;
    logic [3:0] o_rate_code;
    int         n_errors = 0, check_count = 0, cyc = 0;
    apm_power_ctrl #(.BASE_DIV(4), .DIV_W(13)) dut_u (.*);
    apm_host host_u (.i_ref_clk, .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
                     .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
    initial
    begin
        i_ref_clk = 1'b0;
        forever #25 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
        if (++cyc == 5000)
            stop_test(1);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        n_errors += (seen !== exp);
        if (seen !== exp)
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    task automatic stop_test(input int to);
        n_errors += to;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Tick counts over 64 cycles, a whole number of every period used
    task automatic per();
        {n, q} = 16'h0000;
        repeat (32) @(negedge i_ref_clk);
        repeat (64) @(negedge i_ref_clk) {n, q} = {n + o_odr_tick, q + o_sample_tick};
    endtask
    task automatic t_cfg();
        per();
        chk({n[3:0] | q[3:0], 2'h0, o_measure, o_standby}, 8'h01);
        host_u.xfer(0, 8'h2C, 8'h00, q);
        chk(q, 8'h0A);
        host_u.xfer(1, 8'h2C, 8'h1C, q); // low power at 400 Hz, set up in standby
        host_u.xfer(0, 8'h2C, 8'h00, q);
        chk(q, 8'h1C);
        chk({3'h0, o_low_power, o_rate_code}, 8'h1C);
        $display("t_cfg done");
    endtask
    task automatic t_run();
        host_u.xfer(1, 8'h2D, 8'h08, q);
        per();
        chk({n[3:0], q[3:0]}, 8'h22);
        chk({6'h00, o_measure, o_standby}, 8'h02);
        for (int c = 15; c > 10; c--)
        begin
            host_u.xfer(1, 8'h2C, 8'(c), q);
            per();
            chk({n[4:0], q[4:2]}, {5'(16 >> (15 - c)), 3'h4});
        end
        host_u.xfer(1, 8'h2D, 8'h00, q);
        per();
        chk({n[3:0] | q[3:0], 2'h0, o_measure, o_standby}, 8'h01);
        $display("t_run done");
    endtask
    // Mid-run reset while measuring, plus power readback and unmapped access
    task automatic t_rst();
        host_u.xfer(1, 8'h2C, 8'h15, q);
        host_u.xfer(1, 8'h2D, 8'h08, q);
        host_u.xfer(0, 8'h2D, 8'h00, q);
        chk(q, 8'h08);
        chk({7'h00, o_reg_rvalid}, 8'h01);
        @(posedge i_ref_clk);
        #1 chk({7'h00, o_reg_rvalid}, 8'h00);
        host_u.xfer(1, 8'h3F, 8'hFF, q);
        host_u.xfer(0, 8'h3F, 8'h00, q);
        chk(q, 8'h00);
        chk({6'h00, o_measure, o_standby}, 8'h02);
        @(posedge i_ref_clk);
        #1 i_resetn = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        per();
        chk({n[3:0] | q[3:0], 2'h0, o_measure, o_standby}, 8'h01);
        host_u.xfer(0, 8'h2C, 8'h00, q);
        chk(q, 8'h0A);
        host_u.xfer(0, 8'h2D, 8'h00, q);
        chk(q, 8'h00);
        $display("t_rst done");
    endtask
    initial
    begin
        repeat (6) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        t_cfg();
        t_run();
        t_rst();
        stop_test(0);
    end
endmodule
